// [core/cmr_align_detect.sv]
/*
   Synchronises the shared alignment/reset pin and detects alignment edges.
   Assumes the pin is asynchronous to clk_i and enable settings are static
   for a few cycles around an edge.
*/
`timescale 1ns/10ps
module cmr_align_detect
   import cmr_pkg::*;
(
   input wire logic clk_i,
   input wire logic rst_n_i,
   cmr_align_if.det ai
);

   typedef struct packed
   {
      logic s1;
      logic s2;
      logic active;
      logic evt;
   } cmr_det_st_t;

   cmr_det_st_t st_reg;
   cmr_det_st_t st_next;
   logic act_new;

   always_comb
   begin
      st_next = st_reg;
      st_next.s1 = ai.pin;
      st_next.s2 = st_reg.s1;
      act_new = ai.enable && (st_reg.s2 == ai.polarity);
      st_next.active = act_new;
      // Both edges count unless only the leading edge is wanted
      st_next.evt = ai.enable && (act_new != st_reg.active)
         && (!ai.single_edge || act_new);
   end

   always_ff @(posedge clk_i or negedge rst_n_i)
   begin
      if (!rst_n_i)
      begin
         st_reg <= '{s1: 1'b1, s2: 1'b1, default: 1'b0};
      end
      else
      begin
         st_reg <= st_next;
      end
   end

   assign ai.active = st_reg.active;
   assign ai.event_p = st_reg.evt;
   assign ai.level_s = st_reg.s2;

endmodule

// [core/cmr_align_if.sv]
/*
   Carrier between the register bank and its alignment pin detector.
   Assumes both ends run on the same clock.
*/
`timescale 1ns/10ps
interface cmr_align_if;
   logic pin;
   logic enable;
   logic polarity;
   logic single_edge;
   logic active;
   logic event_p;
   logic level_s;

   modport det
   (
      input pin, enable, polarity, single_edge,
      output active, event_p, level_s
   );

   modport ctl
   (
      output pin, enable, polarity, single_edge,
      input active, event_p, level_s
   );
endinterface

// [core/cmr_misc_regs.sv]
/*
   Miscellaneous control register bank of a sensor timing generator.
   Assumes a simple register port clocked by clk_i, and frame/line pulses
   and line count coming from timing logic on the same clock.
*/
// What this block does
// - Writing one to soft reset restores all registers to defaults, bit reads zero
// - Outputs stay inactive while control bit is zero, enable at first frame edge after the update line loads it
// - Pin function bit selects alignment input or active-low reset input, default reset
// - External alignment enable gates the pin; polarity bit picks its active level
// - Clock suspend bit suspends generated clocks while alignment pulse is active
// - Three mask bits mask line pulse, frame pulse, vertical clocks during suspension
// - Single edge bit makes only the leading alignment edge trigger
// - Shutter reset enable resets shutter control after an alignment event
// - General output reset bit resets shutter and general outputs on alignment
// - Field counter increments or clears on each alignment event
// - Software alignment bit triggers one event like the pin, then self-clears
// - Forced shutter reset bit holds shutter control in reset until cleared
// - Timing core reset bar holds core in reset while zero, default zero
// - Oscillator reset bar keeps oscillator powered down while zero, default zero
// - Thirteen-bit update line selects where frame-updated registers load
// - Update block bit holds off all frame-register transfers
// - Gate select field marks which vertical clocks carry sensor gate pulses
// - Override enable lets register gate mask bits replace field register masking
// - Counter width bit, default one, makes the pixel counter fourteen bits
// - Clamp interlock suppresses clamping when preblank and clamp pulse coincide
`timescale 1ns/10ps
module cmr_misc_regs
   import cmr_pkg::*;
(
   input wire logic clk_i,
   input wire logic rst_n_i,
   input wire logic [ADDR_W-1:0] reg_addr_i,
   input wire logic [DATA_W-1:0] reg_wdata_i,
   input wire logic reg_wr_i,
   input wire logic reg_rd_i,
   output logic [DATA_W-1:0] reg_rdata_o,
   input wire logic align_pin_i,
   input wire logic frame_pulse_i,
   input wire logic line_pulse_i,
   input wire logic [LINE_W-1:0] line_count_i,
   input wire logic preblank_window_i,
   input wire logic clamp_pulse_i,
   output logic outputs_active_o,
   output logic pin_reset_n_o,
   output logic timing_core_reset_n_o,
   output logic oscillator_reset_n_o,
   output logic clock_suspend_o,
   output logic line_pulse_mask_o,
   output logic frame_pulse_mask_o,
   output logic vclock_mask_o,
   output logic enhanced_align_o,
   output logic shutter_reset_o,
   output logic genout_reset_o,
   output logic align_event_o,
   output logic [FCNT_W-1:0] field_count_o,
   output logic [GATE_W-1:0] gate_select_o,
   output logic [GATE_W-1:0] gate_mask_o,
   output logic gate_mask_override_o,
   output logic hcount14_o,
   output logic clamp_enable_o
);

   typedef struct packed
   {
      logic out_pend;
      logic out_act;
      cmr_oe_t oe;
      logic [4:0] pin_fn;
      logic [25:0] align;
      logic sw_pend;
      logic core_rst_n;
      logic oscillator_reset_n_n;
      logic [TEST_N-1:0][TEST_W-1:0] test;
      logic [13:0] upd;
      logic [GATE_W-1:0] gsel;
      logic [GATE_W:0] gmask;
      logic [1:0] hopt;
      logic [DATA_W-1:0] rdata;
      logic line_d;
      logic frame_d;
      logic [FCNT_W-1:0] fcnt;
      logic shut_rst;
      logic genout_rst;
      logic evt;
      logic suspend;
      logic m_line;
      logic m_frame;
      logic m_vclk;
      logic clamp_en;
      logic pin_rst_n;
   } cmr_st_t;

   localparam cmr_st_t ST_RST = '{
      oe: OE_OFF,
      pin_fn: PIN_FN_RST,
      align: ALIGN_RST,
      test: {TEST_TEN_RST, TEST_ZERO_RST, TEST_ZERO_RST, TEST_ZERO_RST, TEST_ONE_RST},
      hopt: HOPT_RST,
      clamp_en: 1'b1,
      pin_rst_n: 1'b1,
      default: '0
   };

   cmr_st_t st_reg;
   cmr_st_t st_next;
   cmr_align_if ai ();

   logic soft_wr;
   logic sw_wr;
   logic sw_evt;
   logic sync_evt;
   logic line_rise;
   logic frame_rise;
   logic upd_hit;
   int ti;

   cmr_align_detect u_detect
   (
      .clk_i(clk_i),
      .rst_n_i(rst_n_i),
      .ai(ai)
   );

   // Pin acts as alignment input only when its function bit selects it
   assign ai.pin = align_pin_i;
   assign ai.enable = st_reg.align[B_EXT_EN] && !st_reg.pin_fn[0];
   assign ai.polarity = st_reg.align[B_POL];
   assign ai.single_edge = st_reg.align[B_EDGE];

   assign soft_wr = reg_wr_i && (reg_addr_i == A_SOFT_RST) && reg_wdata_i[0];
   assign sw_wr = reg_wr_i && (reg_addr_i == A_ALIGN) && reg_wdata_i[B_SWS];
   assign sw_evt = st_reg.sw_pend;
   assign sync_evt = ai.event_p || sw_evt;
   assign line_rise = line_pulse_i && !st_reg.line_d;
   assign frame_rise = frame_pulse_i && !st_reg.frame_d;
   assign upd_hit = line_rise && (line_count_i == st_reg.upd[LINE_W-1:0]);

   always_comb
   begin
      st_next = st_reg;
      ti = cmr_test_idx(reg_addr_i);
      st_next.line_d = line_pulse_i;
      st_next.frame_d = frame_pulse_i;
      st_next.rdata = '0;

      // Serial-type registers take the written value on the write itself
      if (reg_wr_i)
      begin
         unique case (reg_addr_i)
            A_OUT_EN: st_next.out_pend = reg_wdata_i[0];
            A_PIN_FN: st_next.pin_fn = reg_wdata_i[4:0];
            A_ALIGN: st_next.align = reg_wdata_i[25:0];
            A_CORE_RST: st_next.core_rst_n = reg_wdata_i[0];
            A_OSCILLATOR_RESET_N: st_next.oscillator_reset_n_n = reg_wdata_i[0];
            A_UPD: st_next.upd = reg_wdata_i[13:0];
            A_GSEL: st_next.gsel = reg_wdata_i[GATE_W-1:0];
            A_GMASK: st_next.gmask = reg_wdata_i[GATE_W:0];
            A_HOPT: st_next.hopt = reg_wdata_i[1:0];
            default:
            begin
               if (ti < TEST_N)
               begin
                  st_next.test[ti] = reg_wdata_i[TEST_W-1:0];
               end
            end
         endcase
      end

      // Command bit is not stored in the word; a new write of one wins over the clear
      st_next.align[B_SWS] = 1'b0;
      st_next.sw_pend = sw_wr;

      // Frame-type register moves to its working copy at the update line
      if (upd_hit && !st_reg.upd[B_UPD_BLK])
      begin
         st_next.out_act = st_reg.out_pend;
      end

      unique case (st_reg.oe)
         OE_OFF:
         begin
            if (st_reg.out_act)
            begin
               st_next.oe = OE_WAIT;
            end
         end
         OE_WAIT:
         begin
            if (!st_reg.out_act)
            begin
               st_next.oe = OE_OFF;
            end
            else if (frame_rise)
            begin
               st_next.oe = OE_ON;
            end
         end
         OE_ON:
         begin
            if (!st_reg.out_act)
            begin
               st_next.oe = OE_OFF;
            end
         end
         default: st_next.oe = OE_OFF;
      endcase

      st_next.evt = sync_evt;
      st_next.genout_rst = sync_evt && st_reg.align[B_GENOUT];
      st_next.shut_rst = st_reg.align[B_FSHUT]
         || (sync_evt && (st_reg.align[B_SHUT] || st_reg.align[B_GENOUT]));
      if (sync_evt)
      begin
         st_next.fcnt = st_reg.align[B_INC] ? FCNT_W'(st_reg.fcnt + 1'b1) : '0;
      end

      st_next.suspend = st_reg.align[B_SUSP] && ai.active;
      st_next.m_line = st_next.suspend && st_reg.align[B_MASK_LINE];
      st_next.m_frame = st_next.suspend && st_reg.align[B_MASK_FRAME];
      st_next.m_vclk = st_next.suspend && st_reg.align[B_MASK_VCLK];

      st_next.clamp_en = !(st_reg.hopt[B_CLAMP_IL] && preblank_window_i
         && clamp_pulse_i);
      st_next.pin_rst_n = st_reg.pin_fn[0] ? ai.level_s : 1'b1;

      // Read data stand in the cycle after the strobe; unmapped addresses read zero
      if (reg_rd_i)
      begin
         unique case (reg_addr_i)
            A_SOFT_RST: st_next.rdata = '0;
            A_OUT_EN: st_next.rdata = {31'h00000000, st_reg.out_pend};
            A_PIN_FN: st_next.rdata = {27'h0000000, st_reg.pin_fn};
            A_ALIGN: st_next.rdata = {6'h00, st_reg.align[25], st_reg.sw_pend,
               st_reg.align[23:0]};
            A_CORE_RST: st_next.rdata = {31'h00000000, st_reg.core_rst_n};
            A_OSCILLATOR_RESET_N: st_next.rdata = {31'h00000000, st_reg.oscillator_reset_n_n};
            A_UPD: st_next.rdata = {18'h00000, st_reg.upd};
            A_GSEL: st_next.rdata = {8'h00, st_reg.gsel};
            A_GMASK: st_next.rdata = {7'h00, st_reg.gmask};
            A_HOPT: st_next.rdata = {30'h00000000, st_reg.hopt};
            default:
            begin
               if (ti < TEST_N)
               begin
                  st_next.rdata = {4'h0, st_reg.test[ti]};
               end
            end
         endcase
      end

      // Soft reset overrides everything else in the same cycle
      if (soft_wr)
      begin
         st_next = ST_RST;
      end
   end

   always_ff @(posedge clk_i or negedge rst_n_i)
   begin
      if (!rst_n_i)
      begin
         st_reg <= ST_RST;
      end
      else
      begin
         st_reg <= st_next;
      end
   end

   assign reg_rdata_o = st_reg.rdata;
   assign outputs_active_o = st_reg.oe[1]; // Only the on code has its upper bit set
   assign pin_reset_n_o = st_reg.pin_rst_n;
   assign timing_core_reset_n_o = st_reg.core_rst_n;
   assign oscillator_reset_n_o = st_reg.oscillator_reset_n_n;
   assign clock_suspend_o = st_reg.suspend;
   assign line_pulse_mask_o = st_reg.m_line;
   assign frame_pulse_mask_o = st_reg.m_frame;
   assign vclock_mask_o = st_reg.m_vclk;
   assign enhanced_align_o = st_reg.align[B_ENH];
   assign shutter_reset_o = st_reg.shut_rst;
   assign genout_reset_o = st_reg.genout_rst;
   assign align_event_o = st_reg.evt;
   assign field_count_o = st_reg.fcnt;
   assign gate_select_o = st_reg.gsel;
   assign gate_mask_o = st_reg.gmask[GATE_W-1:0];
   assign gate_mask_override_o = st_reg.gmask[B_GMASK_EN];
   assign hcount14_o = st_reg.hopt[B_HCNT14];
   assign clamp_enable_o = st_reg.clamp_en;

   default clocking cb @(posedge clk_i);
   endclocking

   default disable iff (!rst_n_i);

   sequence s_sw_write;
      (sw_wr && !soft_wr) ##1 !(sw_wr || soft_wr);
   endsequence

   sequence s_sw_fire;
      st_reg.sw_pend ##1 align_event_o;
   endsequence

   a_soft_reset_defaults: assert property (soft_wr |=> st_reg.pin_fn == PIN_FN_RST
      && st_reg.align == ALIGN_RST && !timing_core_reset_n_o && hcount14_o)
      else $error("soft reset did not restore defaults");

   a_soft_bit_zero: assert property (reg_rd_i && reg_addr_i == A_SOFT_RST
      |=> reg_rdata_o == '0)
      else $error("soft reset bit read nonzero");

   a_outputs_held_off: assert property (!st_reg.out_act |=> !outputs_active_o)
      else $error("outputs active while control bit clear");

   a_outputs_on_frame: assert property ($rose(outputs_active_o)
      |-> $past(frame_rise) && $past(st_reg.out_act))
      else $error("outputs enabled off a frame edge");

   a_pin_as_align: assert property (!st_reg.pin_fn[0] && !soft_wr |=> pin_reset_n_o)
      else $error("reset asserted while pin is alignment input");

   a_suspend_follows: assert property (st_reg.align[B_SUSP] && ai.active && !soft_wr
      |=> clock_suspend_o)
      else $error("clocks not suspended during alignment pulse");

   a_masks_need_suspend: assert property ((frame_pulse_mask_o || line_pulse_mask_o
      || vclock_mask_o) |-> clock_suspend_o)
      else $error("mask active outside suspension");

   a_shutter_on_sync: assert property (sync_evt && st_reg.align[B_SHUT] && !soft_wr
      |=> shutter_reset_o)
      else $error("shutter not reset after alignment");

   a_genout_on_sync: assert property (sync_evt && st_reg.align[B_GENOUT] && !soft_wr
      |=> genout_reset_o && shutter_reset_o)
      else $error("general outputs not reset on alignment");

   a_field_step: assert property (sync_evt && st_reg.align[B_INC] && !soft_wr
      |=> field_count_o == FCNT_W'($past(field_count_o) + 1'b1))
      else $error("field counter did not advance");

   a_field_clear: assert property (sync_evt && !st_reg.align[B_INC] && !soft_wr
      |=> field_count_o == '0)
      else $error("field counter not cleared");

   a_sw_sync_once: assert property (s_sw_write |-> s_sw_fire ##0 !st_reg.sw_pend)
      else $error("software alignment not single shot");

   a_forced_shutter: assert property (st_reg.align[B_FSHUT] && !soft_wr
      |=> shutter_reset_o)
      else $error("shutter released while forced reset set");

   a_update_blocked: assert property (upd_hit && st_reg.upd[B_UPD_BLK] && !soft_wr
      |=> st_reg.out_act == $past(st_reg.out_act))
      else $error("frame register updated while blocked");

   a_clamp_interlock: assert property (st_reg.hopt[B_CLAMP_IL] && preblank_window_i
      && clamp_pulse_i && !soft_wr |=> !clamp_enable_o)
      else $error("clamp not suppressed during preblank");

endmodule

// [core/cmr_pkg.sv]
/*
   Constants for the miscellaneous control register bank: addresses, field
   positions, reset values and shared types.
   Assumes an 8-bit register address and a 32-bit register data path.
*/
package cmr_pkg;

   localparam int ADDR_W = 8;
   localparam int DATA_W = 32;
   localparam int TEST_W = 28;
   localparam int TEST_N = 5;
   localparam int FCNT_W = 5;
   localparam int LINE_W = 13;
   localparam int GATE_W = 24;

   localparam logic [7:0] A_SOFT_RST = 8'h10;
   localparam logic [7:0] A_OUT_EN = 8'h11;
   localparam logic [7:0] A_PIN_FN = 8'h12;
   localparam logic [7:0] A_ALIGN = 8'h13;
   localparam logic [7:0] A_CORE_RST = 8'h14;
   localparam logic [7:0] A_OSCILLATOR_RESET_N = 8'h15;
   localparam logic [7:0] A_TEST_ONE = 8'h16;
   localparam logic [7:0] A_UPD = 8'h17;
   localparam logic [7:0] A_TEST_A = 8'h18;
   localparam logic [7:0] A_TEST_B = 8'h19;
   localparam logic [7:0] A_TEST_C = 8'h1A;
   localparam logic [7:0] A_TEST_TEN = 8'h1B;
   localparam logic [7:0] A_GSEL = 8'h1C;
   localparam logic [7:0] A_GMASK = 8'h1D;
   localparam logic [7:0] A_UNUSED = 8'h1E;
   localparam logic [7:0] A_HOPT = 8'h1F;

   // Field positions in the alignment control word, then in the update, gate mask and option words
   localparam int B_EXT_EN = 0;
   localparam int B_POL = 1;
   localparam int B_SUSP = 2;
   localparam int B_ENH = 3;
   localparam int B_MASK_LINE = 4;
   localparam int B_MASK_FRAME = 5;
   localparam int B_MASK_VCLK = 6;
   localparam int B_EDGE = 14;
   localparam int B_SHUT = 15;
   localparam int B_GENOUT = 16;
   localparam int B_INC = 17;
   localparam int B_SWS = 24;
   localparam int B_FSHUT = 25;
   localparam int B_UPD_BLK = 13;
   localparam int B_GMASK_EN = 24;
   localparam int B_HCNT14 = 0;
   localparam int B_CLAMP_IL = 1;

   localparam logic [4:0] PIN_FN_RST = 5'h01;
   localparam logic [25:0] ALIGN_RST = 26'h0000061;
   localparam logic [1:0] HOPT_RST = 2'h3;
   localparam logic [TEST_W-1:0] TEST_ONE_RST = 28'h0000001;
   localparam logic [TEST_W-1:0] TEST_TEN_RST = 28'h000000A;
   localparam logic [TEST_W-1:0] TEST_ZERO_RST = 28'h0000000;

   typedef enum logic [1:0]
   {
      OE_OFF = 2'b00,
      OE_WAIT = 2'b01,
      OE_ON = 2'b11
   } cmr_oe_t;

   // Test register slot for an address, TEST_N when not a test register
   function automatic int cmr_test_idx(input logic [7:0] a);
      unique case (a)
         A_TEST_ONE: return 0;
         A_TEST_A: return 1;
         A_TEST_B: return 2;
         A_TEST_C: return 3;
         A_TEST_TEN: return 4;
         default: return TEST_N;
      endcase
   endfunction

endpackage

// [verif/cmr_host_model.sv]
/*
   Host model that drives the register port of the control bank.
   Assumes the bank never stalls and answers a read in the next cycle.
*/
`timescale 1ns/10ps
module cmr_host_model
   import cmr_pkg::*;
(
   input wire logic clk_i,
   output logic [ADDR_W-1:0] addr_o,
   output logic [DATA_W-1:0] wdata_o,
   output logic wr_o,
   output logic rd_o,
   input wire logic [DATA_W-1:0] rdata_i
);
   initial
   begin
      addr_o = 8'h00;
      wdata_o = 32'h00000000;
      wr_o = 1'b0;
      rd_o = 1'b0;
   end

   // Released data turns to its inverse so a stale value never looks valid
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      wr_o <= 1'b1;
      addr_o <= a;
      wdata_o <= d;
      @(posedge clk_i);
      wr_o <= 1'b0;
      wdata_o <= ~d;
      @(posedge clk_i);
   endtask

   task automatic rd(input logic [7:0] a, output logic [31:0] d);
      rd_o <= 1'b1;
      addr_o <= a;
      @(posedge clk_i);
      rd_o <= 1'b0;
      @(posedge clk_i);
      d = rdata_i;
   endtask

   // Test slots only ever get their fixed values
   task automatic init_test_regs;
      wr(A_TEST_ONE, 32'h00000001);
      wr(A_TEST_TEN, 32'h0000000A);
   endtask
endmodule

// [verif/cmr_misc_regs_tb.sv]
/*
   Self-checking testbench for the control register bank.
   Assumes the host model in cmr_host_model.sv and a 50 MHz clock.
*/
`timescale 1ns/10ps
module cmr_misc_regs_tb
   import cmr_pkg::*;
;
   logic clk_i, rst_n_i, wr, rd, pin, fp, lp, pb, cp;
   logic [ADDR_W-1:0] addr;
   logic [DATA_W-1:0] wdata, rdata;
   logic [LINE_W-1:0] lc;
   logic act, prst, crst, orst, susp, mline, mframe, mvclk;
   logic shut, gres, ev, ovr, h14, clen, enh;
   logic [FCNT_W-1:0] fcnt;
   logic [GATE_W-1:0] gsel, gmask;
   int errors = 0;
   int num_checks = 0;
   logic [31:0] dflt [16] = '{32'h0, 32'h0, 32'h1, 32'h61, 32'h0, 32'h0, 32'h1,
      32'h0, 32'h0, 32'h0, 32'h0, 32'hA, 32'h0, 32'h0, 32'h0, 32'h3};

   cmr_host_model i_host (.clk_i(clk_i), .addr_o(addr), .wdata_o(wdata),
      .wr_o(wr), .rd_o(rd), .rdata_i(rdata));

   cmr_misc_regs i_dut (.clk_i(clk_i), .rst_n_i(rst_n_i), .reg_addr_i(addr),
      .reg_wdata_i(wdata), .reg_wr_i(wr), .reg_rd_i(rd), .reg_rdata_o(rdata),
      .align_pin_i(pin), .frame_pulse_i(fp), .line_pulse_i(lp), .line_count_i(lc),
      .preblank_window_i(pb), .clamp_pulse_i(cp), .outputs_active_o(act),
      .pin_reset_n_o(prst), .timing_core_reset_n_o(crst),
      .oscillator_reset_n_o(orst), .clock_suspend_o(susp),
      .line_pulse_mask_o(mline), .frame_pulse_mask_o(mframe),
      .vclock_mask_o(mvclk), .enhanced_align_o(enh), .shutter_reset_o(shut),
      .genout_reset_o(gres), .align_event_o(ev), .field_count_o(fcnt),
      .gate_select_o(gsel), .gate_mask_o(gmask), .gate_mask_override_o(ovr),
      .hcount14_o(h14), .clamp_enable_o(clen));

   initial
   begin
      clk_i = 1'b0;
      forever #10 clk_i = ~clk_i;
   end

   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      num_checks++;
      if (seen !== exp)
      begin
         errors++;
         $display("wrong value at %0t: %h, expected %h", $time, seen, exp);
      end
   endtask

   task automatic test_done;
      if (errors == 0 && num_checks > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask

   task automatic cyc(input int n);
      repeat (n) @(posedge clk_i);
   endtask

   task automatic rchk(input logic [7:0] a, input logic [31:0] e);
      logic [31:0] d;
      i_host.rd(a, d);
      chk(d, e);
   endtask

   // Counts events, and events that also reset shutter and general outputs
   task automatic watch(output int e, output int g);
      e = 0;
      g = 0;
      repeat (8)
      begin
         @(posedge clk_i);
         e += int'(ev === 1'b1);
         g += int'(ev === 1'b1 && shut === 1'b1 && gres === 1'b1);
      end
   endtask

   task automatic pulse(input logic is_line, input logic [12:0] n);
      lc <= n;
      lp <= is_line;
      fp <= !is_line;
      cyc(1);
      lp <= 1'b0;
      fp <= 1'b0;
      cyc(3);
   endtask

   task automatic wait_act;
      int k;
      k = 0;
      while (act !== 1'b1 && k < 8)
      begin
         @(posedge clk_i);
         k++;
      end
      chk(32'(act), 32'h1);
      if (k == 8)
         test_done;
   endtask

   task automatic t_defaults;
      chk(32'({act, prst, crst, orst, h14, clen, fcnt}), 32'h260);
      for (int i = 0; i < 16; i++)
         rchk(8'h10 + 8'(i), dflt[i]);
      rchk(8'h20, 32'h0);
   endtask

   task automatic t_writes;
      i_host.wr(A_CORE_RST, 32'h1);
      i_host.wr(A_OSCILLATOR_RESET_N, 32'h1);
      i_host.wr(A_GSEL, 32'h00FFFFFF);
      i_host.wr(A_GMASK, 32'h01ABCDEF);
      i_host.wr(A_HOPT, 32'h0);
      i_host.wr(A_ALIGN, 32'h00000069);
      i_host.wr(8'h30, 32'hFFFFFFFF);
      chk(32'({crst, orst, h14, ovr, enh}), 32'h1B);
      chk(32'(gsel), 32'h00FFFFFF);
      chk(32'(gmask), 32'h00ABCDEF);
      rchk(A_GMASK, 32'h01ABCDEF);
      rchk(A_ALIGN, 32'h00000069);
      rchk(8'h30, 32'h0);
      rchk(A_UNUSED, 32'h0);
   endtask

   task automatic t_soft_reset;
      i_host.wr(A_SOFT_RST, 32'h1);
      cyc(2);
      chk(32'({act, prst, crst, orst, h14, clen, fcnt}), 32'h260);
      chk(32'(gsel), 32'h0);
      rchk(A_SOFT_RST, 32'h0);
      rchk(A_GMASK, 32'h0);
   endtask

   task automatic t_clamp;
      pb <= 1'b1;
      cp <= 1'b1;
      cyc(3);
      chk(32'(clen), 32'h0);
      cp <= 1'b0;
      cyc(3);
      chk(32'(clen), 32'h1);
      i_host.wr(A_HOPT, 32'h1);
      cp <= 1'b1;
      cyc(3);
      chk(32'({clen, h14}), 32'h3);
      pb <= 1'b0;
      cp <= 1'b0;
   endtask

   // Output enable is staged, so it must ride the update line
   task automatic t_out_en;
      i_host.wr(A_UPD, 32'h00002005);
      i_host.wr(A_OUT_EN, 32'h1);
      pulse(1'b1, 13'h5);
      pulse(1'b0, 13'h0);
      chk(32'(act), 32'h0);
      i_host.wr(A_UPD, 32'h5);
      pulse(1'b1, 13'h3);
      pulse(1'b0, 13'h0);
      chk(32'(act), 32'h0);
      pulse(1'b1, 13'h5);
      chk(32'(act), 32'h0);
      pulse(1'b0, 13'h0);
      wait_act;
      i_host.wr(A_OUT_EN, 32'h0);
      cyc(3);
      chk(32'(act), 32'h1);
      pulse(1'b1, 13'h5);
      chk(32'(act), 32'h0);
   endtask

   task automatic t_pin;
      int e, g, e2;
      pin <= 1'b0;
      watch(e, g);
      chk(32'({prst, 4'(e)}), 32'h0);
      pin <= 1'b1;
      cyc(6);
      chk(32'(prst), 32'h1);
      i_host.wr(A_PIN_FN, 32'h0);
      i_host.wr(A_ALIGN, 32'h00038075);
      pin <= 1'b0;
      watch(e, g);
      chk(32'({4'(e), 4'(g)}), 32'h11);
      chk(32'({susp, mline, mframe, mvclk, 3'(fcnt)}), 32'h79);
      pin <= 1'b1;
      watch(e, g);
      chk(32'({4'(e), susp, fcnt}), 32'h42);
      i_host.wr(A_ALIGN, 32'h0003C075);
      pin <= 1'b0;
      watch(e, g);
      pin <= 1'b1;
      watch(e2, g);
      chk(32'({4'(e + e2), fcnt}), 32'h23);
      i_host.wr(A_ALIGN, 32'h00020074);
      pin <= 1'b0;
      watch(e, g);
      pin <= 1'b1;
      watch(e2, g);
      chk(32'({4'(e + e2), fcnt}), 32'h03);
   endtask

   // Software sync fires even with the pin path disabled
   task automatic t_sw_sync;
      int e, g;
      i_host.wr(A_ALIGN, 32'h01020000);
      watch(e, g);
      chk(32'({4'(e), fcnt}), 32'h24);
      rchk(A_ALIGN, 32'h00020000);
      i_host.wr(A_ALIGN, 32'h01000000);
      watch(e, g);
      chk(32'({4'(e), fcnt}), 32'h20);
      i_host.wr(A_ALIGN, 32'h02000000);
      cyc(8);
      chk(32'(shut), 32'h1);
      i_host.wr(A_ALIGN, 32'h0);
      cyc(2);
      chk(32'(shut), 32'h0);
   endtask

   initial
   begin
      rst_n_i = 1'b0;
      pin = 1'b1;
      fp = 1'b0;
      lp = 1'b0;
      pb = 1'b0;
      cp = 1'b0;
      lc = 13'h0;
      cyc(5);
      rst_n_i <= 1'b1;
      cyc(1);
      t_defaults;
      i_host.init_test_regs;
      t_writes;
      t_soft_reset;
      t_clamp;
      t_out_en;
      t_pin;
      t_sw_sync;
      test_done;
   end
endmodule
